// ==== src/adc_input_front_end.sv ====
// converter input front end: pairing, channel select, port mode, clock and gain ranging
// Summary of operation
// - bits 24 and 25 pair ports A/B and C/D as complex I/Q
// - one pair may be complex while the other two ports stay real
// - per channel 3-bit port select plus complex bit takes I and Q
// - paired ports drive gain code only on the I port pins
// - differential mode merges the A/B and C/D clock pairs, data stays per port
// - single-ended mode after reset, bit 10 selects it
// - writing one to bit 8 starts pad termination calibration
// - processing clock is port A clock times M over N, M 4..20
// - M outside 4..20 bypasses the multiplier
// - predivide codes 00,01,10,11 divide by 1,2,4,8
// - multiplier is in bypass after reset
// - gain enable makes exponent pins outputs, default inputs
// - magnitude above upper threshold lowers gain code at once
// - below lower threshold loads 20-bit dwell counter, counts down per sample
// - dwell counter at one raises gain code by one
// - rising above lower threshold abandons the pending increase
// - samples relinearized at 6.02 dB per gain step
// - gain code delayed by programmable 6-bit sample count before use
// - new adjustments ignored while relinearization delay runs
// - enabling gain control sets the gain code to zero
// - complex A/B pair shuts port B gain, B exponent copies A
// - thresholds compared to top 10 bits of sample magnitude
// - exponent right-shifts mantissa arithmetically 0 to 7 places
`timescale 1ns/100ps
`include "adc_fe_defs.svh"
module adc_input_front_end (
   // clock and reset
   input  wire logic                     mclk_i,
   input  wire logic                     rst_n_i,
   // register port
   input  wire logic [3:0]               reg_addr_i,
   input  wire logic [31:0]              reg_wdata_i,
   input  wire logic                     reg_wr_i,
   input  wire logic                     reg_rd_i,
   output logic      [31:0]              reg_rdata_o,
   // port sample strobes, one per sample clock edge
   input  wire logic                     port_a_sample_clock_i,
   input  wire logic                     port_b_sample_clock_i,
   input  wire logic                     port_c_sample_clock_i,
   input  wire logic                     port_d_sample_clock_i,
   // port data
   input  wire logic [15:0]              port_a_sample_in_i,
   input  wire logic [15:0]              port_b_sample_in_i,
   input  wire logic [15:0]              port_c_sample_in_i,
   input  wire logic [15:0]              port_d_sample_in_i,
   // exponent / gain code pins, three signals each
   input  wire logic [2:0]               port_a_gain_code_pins_i,
   output logic      [2:0]               port_a_gain_code_pins_o,
   output logic                          port_a_gain_code_pins_oe_n_o,
   input  wire logic [2:0]               port_b_gain_code_pins_i,
   output logic      [2:0]               port_b_gain_code_pins_o,
   output logic                          port_b_gain_code_pins_oe_n_o,
   input  wire logic [2:0]               port_c_gain_code_pins_i,
   output logic      [2:0]               port_c_gain_code_pins_o,
   output logic                          port_c_gain_code_pins_oe_n_o,
   input  wire logic [2:0]               port_d_gain_code_pins_i,
   output logic      [2:0]               port_d_gain_code_pins_o,
   output logic                          port_d_gain_code_pins_oe_n_o,
   // pad calibration handshake
   output logic                          pad_cal_busy_o,
   input  wire logic                     pad_cal_done_i,
   // processing clock setting
   output logic                          pll_bypass_o,
   output logic      [4:0]               pll_mult_o,
   output logic      [3:0]               pll_div_o,
   output logic                          diff_mode_o,
   // channel outputs
   output adc_fe_pkg::chan_out_type      chan0_o,
   output adc_fe_pkg::chan_out_type      chan1_o,
   output logic                          chan0_valid_o,
   output logic                          chan1_valid_o
);
   import adc_fe_pkg::*;

   logic [31:0]       pair_ff;
   logic [31:0]       diff_ff;
   logic [31:0]       clkctl_ff;
   chan_sel_type      chsel0_ff;
   chan_sel_type      chsel1_ff;
   logic [31:0]       gainctl_ff [4];
   logic [31:0]       thresh_ff  [4];
   logic [19:0]       dwell_ff   [4];
   logic [1:0]        port_sel_ff;
   logic [31:0]       rdata_ff;
   cal_state_type     cal_state_ff;
   logic [7:0]        cal_cnt_ff;
   logic              pair_ab;
   logic              pair_cd;
   logic              single_ended;
   logic [15:0]       mant    [4];
   logic [2:0]        exp_in  [4];
   logic              smp     [4];
   logic              gen     [4];
   logic [2:0]        code    [4];
   logic [15:0]       relin   [4];
   logic              fexp_en [4];
   logic [2:0]        fexp    [4];
   chan_out_type      chan0_ff;
   chan_out_type      chan1_ff;
   logic              v0_ff;
   logic              v1_ff;

   assign pair_ab      = pair_ff[`FE_PAIR_AB_BIT];
   assign pair_cd      = pair_ff[`FE_PAIR_CD_BIT];
   assign single_ended = diff_ff[`FE_DIFF_SE_BIT];

   always_comb begin
      mant[0] = port_a_sample_in_i;
      mant[1] = port_b_sample_in_i;
      mant[2] = port_c_sample_in_i;
      mant[3] = port_d_sample_in_i;
      exp_in[0] = port_a_gain_code_pins_i;
      exp_in[1] = port_b_gain_code_pins_i;
      exp_in[2] = port_c_gain_code_pins_i;
      exp_in[3] = port_d_gain_code_pins_i;
      smp[0] = port_a_sample_clock_i;
      // in differential mode the second port of each pair follows the first clock
      smp[1] = single_ended ? port_b_sample_clock_i : port_a_sample_clock_i;
      smp[2] = port_c_sample_clock_i;
      smp[3] = single_ended ? port_d_sample_clock_i : port_c_sample_clock_i;
      for (int k = 0; k < 4; k++) begin
         gen[k]     = gainctl_ff[k][`FE_GAIN_EN_BIT];
         fexp_en[k] = 1'b0;
         fexp[k]    = 3'h0;
      end
      // the Q port of a pair keeps no gain loop of its own
      if (pair_ab) begin
         gen[1]     = 1'b0;
         fexp_en[1] = gainctl_ff[0][`FE_GAIN_EN_BIT];
         fexp[1]    = code[0];
      end
      if (pair_cd) begin
         gen[3]     = 1'b0;
         fexp_en[3] = gainctl_ff[2][`FE_GAIN_EN_BIT];
         fexp[3]    = code[2];
      end
   end

   for (genvar g = 0; g < 4; g++) begin : gr
      gain_ranger u_gr (
         .mclk_i         (mclk_i),
         .rst_n_i        (rst_n_i),
         .smp_en_i       (smp[g]),
         .mant_i         (mant[g]),
         .exp_in_i       (exp_in[g]),
         .enable_i       (gen[g]),
         .upper_i        (thresh_ff[g][25:16]),
         .lower_i        (thresh_ff[g][9:0]),
         .dwell_i        (dwell_ff[g]),
         .delay_i        (gainctl_ff[g][`FE_DELAY_MSB:`FE_DELAY_LSB]),
         .force_exp_en_i (fexp_en[g]),
         .force_exp_i    (fexp[g]),
         .gain_code_o    (code[g]),
         .relin_o        (relin[g])
      );
   end

   // pins drive only while the port's own loop is enabled
   assign port_a_gain_code_pins_o      = code[0];
   assign port_a_gain_code_pins_oe_n_o = ~gen[0];
   assign port_b_gain_code_pins_o      = code[1];
   assign port_b_gain_code_pins_oe_n_o = ~gen[1];
   assign port_c_gain_code_pins_o      = code[2];
   assign port_c_gain_code_pins_oe_n_o = ~gen[2];
   assign port_d_gain_code_pins_o      = code[3];
   assign port_d_gain_code_pins_oe_n_o = ~gen[3];

   clk_mult_ctl u_clk (
      .mclk_i   (mclk_i),
      .rst_n_i  (rst_n_i),
      .mult_i   (clkctl_ff[4:0]),
      .prediv_i (clkctl_ff[9:8]),
      .bypass_o (pll_bypass_o),
      .mult_o   (pll_mult_o),
      .div_o    (pll_div_o)
   );
   assign diff_mode_o = ~single_ended;

   // register writes
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pair_ff     <= 32'h0000_0000;
         diff_ff     <= `FE_DIFF_RESET;
         clkctl_ff   <= 32'h0000_0000;
         chsel0_ff   <= '0;
         chsel1_ff   <= '0;
         port_sel_ff <= 2'h0;
         for (int k = 0; k < 4; k++) begin
            gainctl_ff[k] <= 32'h0000_0000;
            thresh_ff[k]  <= 32'h0000_0000;
            dwell_ff[k]   <= 20'h0_0000;
         end
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `FE_REG_PAIR:    pair_ff   <= reg_wdata_i;
            `FE_REG_DIFF:    diff_ff   <= reg_wdata_i & ~(32'h1 << `FE_DIFF_CAL_BIT);
            `FE_REG_CLKCTL:  clkctl_ff <= reg_wdata_i;
            `FE_REG_CHSEL: begin
               chsel0_ff <= reg_wdata_i[3:0];
               chsel1_ff <= reg_wdata_i[7:4];
            end
            `FE_REG_PORTSEL: port_sel_ff <= reg_wdata_i[1:0];
            `FE_REG_GAINCTL: gainctl_ff[port_sel_ff] <= reg_wdata_i;
            `FE_REG_THRESH:  thresh_ff[port_sel_ff]  <= reg_wdata_i;
            `FE_REG_DWELL:   dwell_ff[port_sel_ff]   <= reg_wdata_i[19:0];
            default: ;
         endcase
      end
   end

   // pad calibration: ends on the pad's done or a bounded timeout
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cal_state_ff <= cal_idle_type;
         cal_cnt_ff   <= 8'h00;
      end else begin
         case (cal_state_ff)
            cal_idle_type: begin
               if (reg_wr_i && reg_addr_i == `FE_REG_DIFF && reg_wdata_i[`FE_DIFF_CAL_BIT]) begin
                  cal_state_ff <= cal_run_type;
                  cal_cnt_ff   <= `FE_CAL_CYCLES;
               end
            end
            cal_run_type: begin
               cal_cnt_ff <= cal_cnt_ff - 8'h01;
               if (pad_cal_done_i || cal_cnt_ff == 8'h01) begin
                  cal_state_ff <= cal_done_type;
               end
            end
            cal_done_type: cal_state_ff <= cal_idle_type;
            default:       cal_state_ff <= cal_idle_type;
         endcase
      end
   end
   assign pad_cal_busy_o = (cal_state_ff == cal_run_type);

   // channel crossbar; complex takes the pair's Q from the next port
   function automatic chan_out_type pick(input chan_sel_type s, input logic [15:0] r [4],
                                         input logic pab, input logic pcd);
      chan_out_type o;
      logic [1:0]   p;
      o = '0;
      p = s.port_sel[1:0];
      if (s.port_sel[2]) begin
         o = '0;
      end else begin
         o.i_data = r[p];
         if (s.cplx && ((p == 2'd0 && pab) || (p == 2'd2 && pcd))) begin
            o.q_data  = r[p + 2'd1];
            o.is_cplx = 1'b1;
         end
      end
      return o;
   endfunction

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         chan0_ff <= '0;
         chan1_ff <= '0;
         v0_ff    <= 1'b0;
         v1_ff    <= 1'b0;
      end else begin
         chan0_ff <= pick(chsel0_ff, relin, pair_ab, pair_cd);
         chan1_ff <= pick(chsel1_ff, relin, pair_ab, pair_cd);
         v0_ff    <= ~chsel0_ff.port_sel[2];
         v1_ff    <= ~chsel1_ff.port_sel[2];
      end
   end
   assign chan0_o       = chan0_ff;
   assign chan1_o       = chan1_ff;
   assign chan0_valid_o = v0_ff;
   assign chan1_valid_o = v1_ff;

   // register reads, data in the following cycle
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rdata_ff <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `FE_REG_PAIR:    rdata_ff <= pair_ff;
            `FE_REG_DIFF:    rdata_ff <= diff_ff;
            `FE_REG_CLKCTL:  rdata_ff <= clkctl_ff;
            `FE_REG_CHSEL:   rdata_ff <= {24'h0, chsel1_ff, chsel0_ff};
            `FE_REG_PORTSEL: rdata_ff <= {30'h0, port_sel_ff};
            `FE_REG_GAINCTL: rdata_ff <= gainctl_ff[port_sel_ff];
            `FE_REG_THRESH:  rdata_ff <= thresh_ff[port_sel_ff];
            `FE_REG_DWELL:   rdata_ff <= {12'h0, dwell_ff[port_sel_ff]};
            `FE_REG_STATUS:  rdata_ff <= {18'h0, pad_cal_busy_o, pll_bypass_o,
                                          code[3], code[2], code[1], code[0]};
            default:         rdata_ff <= 32'h0000_0000;
         endcase
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end
   assign reg_rdata_o = rdata_ff;
endmodule

// ==== shared/adc_fe_defs.svh ====
// constants for the converter input front end
`ifndef ADC_FE_DEFS_SVH
`define ADC_FE_DEFS_SVH
`define FE_REG_PAIR       4'h0
`define FE_REG_DIFF       4'h1
`define FE_REG_CLKCTL     4'h2
`define FE_REG_CHSEL      4'h3
`define FE_REG_GAINCTL    4'h4
`define FE_REG_THRESH     4'h5
`define FE_REG_DWELL      4'h6
`define FE_REG_STATUS     4'h7
`define FE_REG_PORTSEL    4'h8
`define FE_PAIR_AB_BIT    24
`define FE_PAIR_CD_BIT    25
`define FE_DIFF_CAL_BIT   8
`define FE_DIFF_SE_BIT    10
`define FE_DIFF_RESET     32'h0000_0400
`define FE_MULT_LO        5'h04
`define FE_MULT_HI        5'h14
`define FE_MULT_RESET     5'h00
`define FE_CAL_CYCLES     8'h40
`define FE_EXP_MAX        3'h7
`define FE_EXP_MIN        3'h0
`define FE_DWELL_DONE     20'h0_0001
`define FE_MAG_MSB        15
`define FE_MAG_LSB        6
`define FE_GAIN_EN_BIT    0
`define FE_DELAY_LSB      8
`define FE_DELAY_MSB      13
`endif

// ==== shared/adc_fe_pkg.sv ====
// types for the converter input front end
package adc_fe_pkg;
   typedef struct packed {
      logic [15:0] mant;
      logic [2:0]  exp;
   } sample_type;
   typedef struct packed {
      logic [2:0] port_sel;
      logic       cplx;
   } chan_sel_type;
   typedef struct packed {
      logic [15:0] i_data;
      logic [15:0] q_data;
      logic        is_cplx;
   } chan_out_type;
   typedef enum logic [1:0] {
      cal_idle_type = 2'b00,
      cal_run_type  = 2'b01,
      cal_done_type = 2'b10
   } cal_state_type;
endpackage

// ==== src/gain_ranger.sv ====
// per-port gain ranging: threshold compare, dwell hysteresis, relinearization
`timescale 1ns/100ps
`include "adc_fe_defs.svh"
module gain_ranger (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // port sample strobe and data
   input  wire logic        smp_en_i,
   input  wire logic [15:0] mant_i,
   input  wire logic [2:0]  exp_in_i,
   // control
   input  wire logic        enable_i,
   input  wire logic [9:0]  upper_i,
   input  wire logic [9:0]  lower_i,
   input  wire logic [19:0] dwell_i,
   input  wire logic [5:0]  delay_i,
   // forced exponent in, results out
   input  wire logic        force_exp_en_i,
   input  wire logic [2:0]  force_exp_i,
   output logic      [2:0]  gain_code_o,
   output logic      [15:0] relin_o
);
   logic [2:0]  gain_ff;
   logic [19:0] dwell_ff;
   logic        dwell_run_ff;
   logic [5:0]  delay_ff;
   logic        delay_run_ff;
   logic [2:0]  exp_ff;
   logic [15:0] relin_ff;
   logic        en_d_ff;
   logic [15:0] abs_mag;
   logic [9:0]  mag10;
   logic        over;
   logic        under;
   logic        busy;
   logic [2:0]  use_exp;

   always_comb begin
      abs_mag = mant_i[15] ? 16'(~mant_i + 16'h0001) : mant_i;
      mag10   = abs_mag[`FE_MAG_MSB:`FE_MAG_LSB];
      over    = mag10 > upper_i;
      under   = mag10 < lower_i;
      busy    = delay_run_ff || (gain_ff != exp_ff);
   end

   // gain code with dwell hysteresis, one compare per sample
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         gain_ff      <= 3'h0;
         dwell_ff     <= 20'h0_0000;
         dwell_run_ff <= 1'b0;
         en_d_ff      <= 1'b0;
      end else begin
         en_d_ff <= enable_i;
         if (enable_i && !en_d_ff) begin
            gain_ff      <= `FE_EXP_MIN;
            dwell_run_ff <= 1'b0;
         end else if (enable_i && smp_en_i) begin
            if (over) begin
               dwell_run_ff <= 1'b0;
               if (!busy && gain_ff != `FE_EXP_MIN) begin
                  gain_ff <= gain_ff - 3'h1;
               end
            end else if (under) begin
               if (!dwell_run_ff) begin
                  dwell_ff     <= dwell_i;
                  dwell_run_ff <= 1'b1;
               end else if (dwell_ff <= `FE_DWELL_DONE) begin
                  dwell_run_ff <= 1'b0;
                  if (!busy && gain_ff != `FE_EXP_MAX) begin
                     gain_ff <= gain_ff + 3'h1;
                  end
               end else begin
                  dwell_ff <= dwell_ff - 20'h0_0001;
               end
            end else begin
               dwell_run_ff <= 1'b0;
            end
         end
      end
   end

   // relinearization delay: new exponent takes effect after delay_i samples
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         delay_ff     <= 6'h00;
         delay_run_ff <= 1'b0;
         exp_ff       <= 3'h0;
      end else if (!enable_i) begin
         delay_run_ff <= 1'b0;
         exp_ff       <= 3'h0;
      end else if (smp_en_i) begin
         if (delay_run_ff) begin
            if (delay_ff <= 6'h01) begin
               delay_run_ff <= 1'b0;
               exp_ff       <= gain_ff;
            end else begin
               delay_ff <= delay_ff - 6'h01;
            end
         end else if (gain_ff != exp_ff) begin
            if (delay_i == 6'h00) begin
               exp_ff <= gain_ff;
            end else begin
               delay_ff     <= delay_i;
               delay_run_ff <= 1'b1;
            end
         end
      end
   end

   always_comb begin
      if (force_exp_en_i) begin
         use_exp = force_exp_i;
      end else if (enable_i) begin
         use_exp = exp_ff;
      end else begin
         use_exp = exp_in_i;
      end
   end

   // 6.02 dB per step is one arithmetic shift place
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         relin_ff <= 16'h0000;
      end else if (smp_en_i) begin
         relin_ff <= 16'($signed(mant_i) >>> use_exp);
      end
   end

   assign gain_code_o = gain_ff;
   assign relin_o     = relin_ff;
endmodule

// ==== src/clk_mult_ctl.sv ====
// processing clock multiplier setting decode
`timescale 1ns/100ps
`include "adc_fe_defs.svh"
module clk_mult_ctl (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   // setting
   input  wire logic [4:0] mult_i,
   input  wire logic [1:0] prediv_i,
   // decoded
   output logic            bypass_o,
   output logic      [4:0] mult_o,
   output logic      [3:0] div_o
);
   logic       bypass_ff;
   logic [4:0] mult_ff;
   logic [3:0] div_ff;

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         bypass_ff <= 1'b1;
         mult_ff   <= 5'h01;
         div_ff    <= 4'h1;
      end else begin
         bypass_ff <= (mult_i < `FE_MULT_LO) || (mult_i > `FE_MULT_HI);
         mult_ff   <= ((mult_i < `FE_MULT_LO) || (mult_i > `FE_MULT_HI)) ? 5'h01 : mult_i;
         case (prediv_i)
            2'b00:   div_ff <= 4'h1;
            2'b01:   div_ff <= 4'h2;
            2'b10:   div_ff <= 4'h4;
            2'b11:   div_ff <= 4'h8;
            default: div_ff <= 4'h1;
         endcase
      end
   end

   assign bypass_o = bypass_ff;
   assign mult_o   = mult_ff;
   assign div_o    = div_ff;
endmodule

// ==== verif/adc_fe_monitor.sv ====
// assertions on the front end top ports
`timescale 1ns/100ps
module adc_fe_monitor (
   // clock, reset, register port
   input logic        mclk_i,
   input logic        rst_n_i,
   input logic [3:0]  reg_addr_i,
   input logic [31:0] reg_wdata_i,
   input logic        reg_wr_i,
   // watched port A sample clock and outputs
   input logic        port_a_sample_clock_i,
   input logic [2:0]  port_a_gain_code_pins_o,
   input logic        port_a_gain_code_pins_oe_n_o,
   input logic        port_b_gain_code_pins_oe_n_o,
   input logic        pad_cal_busy_o,
   input logic        pll_bypass_o,
   input logic [4:0]  pll_mult_o,
   input logic [3:0]  pll_div_o,
   input logic        diff_mode_o
);
   logic       pab_ff;
   logic       se_ff;
   logic [1:0] ps_ff;
   logic [4:0] m_ff;
   logic [1:0] n_ff;
   wire        wr_pll = reg_wr_i && reg_addr_i == 4'h2;
   wire        in_rng = reg_wdata_i[4:0] >= 5'h04 && reg_wdata_i[4:0] <= 5'h14;
   wire        en_a = reg_wr_i && reg_addr_i == 4'h4 && reg_wdata_i[0] && ps_ff == 2'h0;
   wire        drv_a = !port_a_gain_code_pins_oe_n_o;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pab_ff <= 1'b0;
         se_ff <= 1'b1;
         ps_ff <= 2'h0;
      end else if (reg_wr_i) begin
         if (reg_addr_i == 4'h0) pab_ff <= reg_wdata_i[24];
         if (reg_addr_i == 4'h1) se_ff <= reg_wdata_i[10];
         if (reg_addr_i == 4'h8) ps_ff <= reg_wdata_i[1:0];
         if (wr_pll) {n_ff, m_ff} <= {reg_wdata_i[9:8], reg_wdata_i[4:0]};
      end
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   a_reset_state: assert property ($rose(rst_n_i) |-> pll_bypass_o && !diff_mode_o
      && !pad_cal_busy_o && port_a_gain_code_pins_oe_n_o) else $error("bad reset state");
   a_pll_ratio: assert property (wr_pll && in_rng |-> ##[2:3] (!pll_bypass_o
      && pll_mult_o == m_ff && pll_div_o == 4'h1 << n_ff)) else $error("bad pll ratio");
   a_pll_bypass: assert property (wr_pll && !in_rng |-> ##[2:3] pll_bypass_o)
      else $error("no pll bypass");
   a_cal_start: assert property (reg_wr_i && reg_addr_i == 4'h1 && reg_wdata_i[8]
      |=> pad_cal_busy_o) else $error("cal not started");
   a_cal_bound: assert property ($rose(pad_cal_busy_o) |-> ##[1:66] !pad_cal_busy_o)
      else $error("cal never ends");
   a_mode_bit: assert property (se_ff == !diff_mode_o) else $error("bad port mode");
   a_b_silent: assert property (pab_ff |-> port_b_gain_code_pins_oe_n_o)
      else $error("paired q port drives");
   a_enable_zero: assert property (en_a |-> ##[1:2] (drv_a
      && port_a_gain_code_pins_o == 3'h0)) else $error("enable not zero");
   a_code_step: assert property (drv_a && $past(drv_a) && $changed(port_a_gain_code_pins_o)
      |-> $past(port_a_sample_clock_i)
      && ({1'b0, port_a_gain_code_pins_o} == {1'b0, $past(port_a_gain_code_pins_o)} + 4'h1
      || {1'b0, $past(port_a_gain_code_pins_o)} == {1'b0, port_a_gain_code_pins_o} + 4'h1))
      else $error("bad gain step");
   c_pll: cover property (wr_pll && in_rng);
   c_cal: cover property ($rose(pad_cal_busy_o));
   c_gain: cover property (drv_a && $changed(port_a_gain_code_pins_o));
endmodule

// ==== verif/adc_src_model.sv ====
// gain-ranging converter model feeding one input port
`timescale 1ns/100ps
module adc_src_model #(parameter int PERIOD = 4) (
   // clock and level to send
   input  wire logic        mclk_i,
   input  wire logic [15:0] level_i,
   // gain pins of the front end
   input  wire logic [2:0]  gain_i,
   input  wire logic        gain_oe_n_i,
   // port side
   output logic             smp_clk_o,
   output logic      [15:0] smp_o,
   output logic      [2:0]  exp_o
);
   int cnt_ff = 0;
   always_ff @(posedge mclk_i) begin
      cnt_ff <= (cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
   end
   assign smp_clk_o = (cnt_ff == 0);
   assign smp_o = level_i;
   // fixed-point source: own exponent zero while the front end is not driving
   assign exp_o = gain_oe_n_i ? 3'h0 : gain_i;
endmodule

// ==== verif/tb_adc_input_front_end.sv ====
// self-checking front end bench
`timescale 1ns/100ps
module tb_adc_input_front_end;
   import adc_fe_pkg::*;
   logic         mclk_i = 1'b0;
   logic         rst_n_i = 1'b0;
   logic  [3:0]  reg_addr_i = 4'h0;
   logic  [31:0] reg_wdata_i = 32'h0;
   logic         reg_wr_i = 1'b0;
   logic         reg_rd_i = 1'b0;
   logic         cal_done = 1'b0;
   logic  [31:0] reg_rdata_o;
   logic  [3:0]  sclk, oe_n;
   logic  [15:0] sdat [4];
   logic  [15:0] lvl [4] = '{default: 16'h4000};
   logic  [2:0]  expi [4];
   logic  [2:0]  code [4];
   logic         byp, busy, diff, v0, v1;
   logic  [4:0]  mult;
   logic  [3:0]  div;
   logic  [4:0]  mv [4] = '{5'h03, 5'h04, 5'h14, 5'h15};
   chan_out_type ch0, ch1;
   int           miscompares = 0;
   int           n_compared = 0;
   for (genvar g = 0; g < 4; g++) begin : g_src
      adc_src_model i_src (.mclk_i(mclk_i), .level_i(lvl[g]), .gain_i(code[g]),
         .gain_oe_n_i(oe_n[g]), .smp_clk_o(sclk[g]), .smp_o(sdat[g]), .exp_o(expi[g]));
   end
   adc_input_front_end i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .port_a_sample_clock_i(sclk[0]),
      .port_b_sample_clock_i(sclk[1]), .port_c_sample_clock_i(sclk[2]),
      .port_d_sample_clock_i(sclk[3]), .port_a_sample_in_i(sdat[0]),
      .port_b_sample_in_i(sdat[1]), .port_c_sample_in_i(sdat[2]), .port_d_sample_in_i(sdat[3]),
      .port_a_gain_code_pins_i(expi[0]), .port_a_gain_code_pins_o(code[0]),
      .port_a_gain_code_pins_oe_n_o(oe_n[0]), .port_b_gain_code_pins_i(expi[1]),
      .port_b_gain_code_pins_o(code[1]), .port_b_gain_code_pins_oe_n_o(oe_n[1]),
      .port_c_gain_code_pins_i(expi[2]), .port_c_gain_code_pins_o(code[2]),
      .port_c_gain_code_pins_oe_n_o(oe_n[2]), .port_d_gain_code_pins_i(expi[3]),
      .port_d_gain_code_pins_o(code[3]), .port_d_gain_code_pins_oe_n_o(oe_n[3]),
      .pad_cal_busy_o(busy), .pad_cal_done_i(cal_done), .pll_bypass_o(byp),
      .pll_mult_o(mult), .pll_div_o(div), .diff_mode_o(diff), .chan0_o(ch0), .chan1_o(ch1),
      .chan0_valid_o(v0), .chan1_valid_o(v1));
   initial forever #4 mclk_i = ~mclk_i;
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 cmp(reg_rdata_o, e);
   endtask
   task automatic wait_smp(input int n);
      repeat (n) @(posedge mclk_i iff sclk[0]);
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #400000;
      miscompares++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      rdc(4'h1, 32'h0000_0400);
      rdc(4'h7, 32'h0000_1000);
      wr(4'h9, 32'hffff_ffff);
      rdc(4'h9, 32'h0);
      $display("reset test done");
      for (int n = 0; n < 4; n++) begin
         wr(4'h2, {22'h0, n[1:0], 3'h0, 5'h06});
         repeat (3) @(posedge mclk_i);
         cmp({byp, mult, div}, {1'b0, 5'h06, 4'h1 << n});
      end
      foreach (mv[k]) begin
         wr(4'h2, 32'h300 | mv[k]);
         repeat (3) @(posedge mclk_i);
         cmp(byp, mv[k] < 5'h04 || mv[k] > 5'h14);
      end
      $display("clock test done");
      wr(4'h1, 32'h0000_0100);
      #1 cmp({diff, busy}, 2'b11);
      @(posedge mclk_i);
      cal_done <= 1'b1;
      @(posedge mclk_i);
      cal_done <= 1'b0;
      rdc(4'h1, 32'h0);
      wr(4'h1, 32'h0000_0400);
      $display("mode test done");
      wr(4'h3, 32'h0);
      wr(4'h5, {6'h0, 10'h180, 6'h0, 10'h040});
      wr(4'h6, 32'h4);
      wr(4'h4, 32'h0000_0e01);
      repeat (2) @(posedge mclk_i);
      cmp({oe_n[0], code[0]}, 4'h0);
      lvl[0] <= 16'h0100;
      wait_smp(2);
      lvl[0] <= 16'h4000;
      wait_smp(3);
      cmp(code[0], 3'h0);
      lvl[0] <= 16'h0100;
      wait_smp(5);
      cmp(code[0], 3'h0);
      wait_smp(1);
      cmp(code[0], 3'h1);
      lvl[0] <= 16'h7fff;
      wait_smp(3);
      lvl[0] <= 16'hc000;
      wait_smp(10);
      cmp(ch0.i_data, 16'hc000);
      wait_smp(6);
      cmp({code[0], ch0.i_data, v0}, {3'h1, 16'he000, 1'b1});
      lvl[0] <= 16'h7fff;
      wait_smp(40);
      cmp(code[0], 3'h0);
      lvl[0] <= 16'h4000;
      $display("gain test done");
      wr(4'h0, 32'h0100_0000);
      wr(4'h3, 32'h0000_0041);
      wr(4'h8, 32'h1);
      wr(4'h4, 32'h0000_0e01);
      wait_smp(3);
      cmp({ch0.is_cplx, ch0.q_data, oe_n[1]}, {1'b1, 16'h4000, 1'b1});
      cmp({ch1.is_cplx, ch1.i_data, v1}, {1'b0, 16'h4000, 1'b1});
      $display("pairing test done");
      report_and_stop();
   end
endmodule
bind adc_input_front_end adc_fe_monitor i_mon (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .port_a_sample_clock_i(port_a_sample_clock_i),
   .port_a_gain_code_pins_o(port_a_gain_code_pins_o),
   .port_a_gain_code_pins_oe_n_o(port_a_gain_code_pins_oe_n_o),
   .port_b_gain_code_pins_oe_n_o(port_b_gain_code_pins_oe_n_o),
   .pad_cal_busy_o(pad_cal_busy_o), .pll_bypass_o(pll_bypass_o), .pll_mult_o(pll_mult_o),
   .pll_div_o(pll_div_o), .diff_mode_o(diff_mode_o));
